// File: rtl/cvi_pkg.sv
package cvi_pkg;
   typedef enum logic [1:0] {CVI_IDLE, CVI_WAIT, CVI_RUN} cvi_mode_t;
endpackage : cvi_pkg

// File: rtl/cvi_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "cvi_regs.svh"

module cvi_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         nrst,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   localparam logic [PW-1:0] LAST = PW'(D - 1);
   localparam logic [CW-1:0] FULL = CW'(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW-1:0]       wp;
      logic [PW-1:0]       rp;
      logic [CW-1:0]       cnt;
   } cvi_fifo_st_t;

   cvi_fifo_st_t r;
   cvi_fifo_st_t r_nxt;
   logic         wr;
   logic         rd;

   assign in_ready  = (r.cnt != FULL);
   assign out_valid = (r.cnt != '0);
   assign out_data  = r.mem[r.rp];
   assign wr        = in_valid & in_ready;
   assign rd        = out_valid & out_ready;

   always_comb begin
      r_nxt = r;
      if (wr) begin
         r_nxt.mem[r.wp] = in_data;
         r_nxt.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
      end
      if (rd) begin
         r_nxt.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
      end
      if (wr & ~rd) begin
         r_nxt.cnt = r.cnt + 1'b1;
      end else if (rd & ~wr) begin
         r_nxt.cnt = r.cnt - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_fifo_bound : assert property (r.cnt <= FULL)
      else $error("pixel buffer count beyond depth");
   a_fifo_full_hold : assert property (!in_ready && !rd |=> !in_ready)
      else $error("pixel buffer full flag dropped without a read");
endmodule : cvi_fifo

module cvi_port #(
   parameter int BPS       = 8,
   parameter int PLANES    = 3,
   parameter bit SEQ_ALLOW = 1'b1,
   parameter bit DE_ON     = 1'b0,
   parameter int STD_W     = 1,
   parameter int DEPTH     = 8
) (
   // Clock and reset; core_clk is the stream clock
   input  wire logic                     core_clk,
   input  wire logic                     nrst,
   // Clocked video input
   input  wire logic                     vid_clk,
   input  wire logic [BPS*PLANES-1:0]    vid_data,
   input  wire logic                     vid_datavalid,
   input  wire logic                     vid_f,
   input  wire logic                     vid_h_sync,
   input  wire logic                     vid_v_sync,
   input  wire logic                     plane_format_select,
   input  wire logic                     vid_locked,
   input  wire logic                     active_region_enable,
   input  wire logic [STD_W-1:0]         vid_std,
   // Stream output
   output logic [BPS*PLANES-1:0]         stream_pixel_bus,
   output logic                          stream_frame_begin,
   output logic                          stream_frame_end,
   output logic                          stream_beat_valid,
   input  wire logic                     stream_sink_ready,
   // Overflow and synchronisation outputs
   output logic                          overflow,
   output logic                          refclk_div,
   output logic                          sof,
   output logic                          sof_locked,
   // Control port
   input  wire logic [`CVI_IDX_W-1:0]    ctrl_word_index,
   input  wire logic                     ctrl_read_strobe,
   input  wire logic                     ctrl_write_strobe,
   input  wire logic [`CVI_BUS_W-1:0]    ctrl_write_bus,
   output logic [`CVI_BUS_W-1:0]         ctrl_read_bus,
   output logic                          status_update_int
);
   localparam int DW = BPS * PLANES;
   localparam int FW = DW + 2;
   localparam int VW = 8 + STD_W + DW;
   localparam int SOP = DW + 1;
   localparam int EOP = DW;
   localparam logic [1:0] PLAST = 2'(PLANES - 1);

   typedef struct packed {
      logic [VW-1:0]           s1;
      logic [VW-1:0]           s2;
      logic                    clk_d;
      logic                    hs_d;
      logic                    vs_d;
      logic                    lock_d;
      cvi_pkg::cvi_mode_t      mode;
      logic                    go;
      logic                    int_en;
      logic                    ovf;
      logic                    int_flag;
      logic [`CVI_SMP_W-1:0]   sof_smp;
      logic [`CVI_LINE_W-1:0]  sof_line;
      logic [`CVI_SMP_W-1:0]   smp_cnt;
      logic [`CVI_LINE_W-1:0]  line_cnt;
      logic [1:0]              plane_cnt;
      logic [DW-1:0]           asm_w;
      logic                    first;
      logic                    pend_v;
      logic                    pend_sop;
      logic [DW-1:0]           pend_d;
      logic                    push_v;
      logic [FW-1:0]           push_w;
      logic                    refclk;
      logic                    sof;
      logic                    seen_sof;
      logic                    sof_lock;
      logic                    out_v;
      logic [FW-1:0]           out_w;
      logic [`CVI_BUS_W-1:0]   rdata;
   } cvi_port_st_t;

   cvi_port_st_t      r;
   cvi_port_st_t      r_nxt;
   logic              v_clk, v_dv, v_f, v_hs, v_vs, v_par, v_lock, v_de;
   logic [STD_W-1:0]  v_std;
   logic [DW-1:0]     v_data;
   logic              smp, hs_rise, vs_rise, vs_fall, act, seq;
   logic              f_in_ready, f_out_valid, take;
   logic [FW-1:0]     f_out_data;
   logic [`CVI_BUS_W-1:0] std_word;

   // Video inputs sampled via the second synchroniser stage only.
   assign {v_clk, v_dv, v_f, v_hs, v_vs, v_par, v_lock, v_de, v_std, v_data} = r.s2;
   // Sample on the falling video clock edge, mid-way between source launches.
   assign smp     = r.clk_d & ~v_clk;
   assign hs_rise = smp & v_hs & ~r.hs_d;
   assign vs_rise = smp & v_vs & ~r.vs_d;
   assign vs_fall = smp & ~v_vs & r.vs_d;
   assign act     = v_dv & ~v_hs & ~v_vs & (~DE_ON | v_de);
   assign seq     = SEQ_ALLOW & ~v_par;
   assign take    = ~r.out_v | stream_sink_ready;
   assign std_word = `CVI_BUS_W'(v_std);

   always_comb begin
      r_nxt = r;
      r_nxt.s1 = {vid_clk, vid_datavalid, vid_f, vid_h_sync, vid_v_sync,
                  plane_format_select, vid_locked, active_region_enable, vid_std, vid_data};
      r_nxt.s2 = r.s1;
      r_nxt.clk_d = v_clk;
      r_nxt.push_v = 1'b0;
      r_nxt.refclk = hs_rise;
      if (smp) begin
         r_nxt.hs_d = v_hs;
         r_nxt.vs_d = v_vs;
         r_nxt.lock_d = v_lock;
         if (v_lock != r.lock_d) begin
            r_nxt.int_flag = 1'b1;
         end
         if (vs_rise) begin
            r_nxt.line_cnt = '0;
         end else if (hs_rise) begin
            r_nxt.line_cnt = r.line_cnt + 1'b1;
         end
         if (hs_rise) begin
            r_nxt.smp_cnt = '0;
            r_nxt.plane_cnt = '0;
            r_nxt.sof = 1'b0;
         end else if (v_dv) begin
            r_nxt.smp_cnt = r.smp_cnt + 1'b1;
            if (r.line_cnt == r.sof_line && r.smp_cnt == r.sof_smp) begin
               r_nxt.sof = 1'b1;
               r_nxt.seen_sof = 1'b1;
            end
         end
         case (r.mode)
            cvi_pkg::CVI_IDLE: begin
               if (r.go) begin
                  r_nxt.mode = cvi_pkg::CVI_WAIT;
               end
            end
            cvi_pkg::CVI_WAIT: begin
               if (!r.go) begin
                  r_nxt.mode = cvi_pkg::CVI_IDLE;
               end else if (vs_fall && v_lock) begin
                  r_nxt.mode = cvi_pkg::CVI_RUN;
                  r_nxt.first = 1'b1;
                  r_nxt.plane_cnt = '0;
               end
            end
            cvi_pkg::CVI_RUN: begin
               if (vs_rise || !v_lock) begin
                  // The held-back pixel closes the frame.
                  r_nxt.push_v = r.pend_v;
                  r_nxt.push_w = {r.pend_sop, 1'b1, r.pend_d};
                  r_nxt.pend_v = 1'b0;
                  r_nxt.first = 1'b1;
                  if (!r.go || !v_lock) begin
                     r_nxt.mode = cvi_pkg::CVI_IDLE;
                  end
               end else if (act && !hs_rise) begin
                  r_nxt.asm_w = {v_data[BPS-1:0], r.asm_w[DW-1:BPS]};
                  if (!seq || r.plane_cnt == PLAST) begin
                     r_nxt.plane_cnt = '0;
                     r_nxt.push_v = r.pend_v;
                     r_nxt.push_w = {r.pend_sop, 1'b0, r.pend_d};
                     r_nxt.pend_v = 1'b1;
                     r_nxt.pend_sop = r.first;
                     r_nxt.pend_d = seq ? r_nxt.asm_w : v_data;
                     r_nxt.first = 1'b0;
                  end else begin
                     r_nxt.plane_cnt = r.plane_cnt + 1'b1;
                  end
               end
            end
            default: r_nxt.mode = cvi_pkg::CVI_IDLE;
         endcase
      end
      if (!smp && !v_lock && r.mode == cvi_pkg::CVI_RUN) begin
         // A source that stops its clock when it unlocks still gets its frame closed.
         r_nxt.push_v = r.pend_v;
         r_nxt.push_w = {r.pend_sop, 1'b1, r.pend_d};
         r_nxt.pend_v = 1'b0;
         r_nxt.first = 1'b1;
         r_nxt.mode = cvi_pkg::CVI_IDLE;
      end
      if (!v_lock) begin
         r_nxt.seen_sof = 1'b0;
      end
      r_nxt.sof_lock = v_lock & r.seen_sof & (r.mode == cvi_pkg::CVI_RUN);
      if (take) begin
         r_nxt.out_v = f_out_valid;
         r_nxt.out_w = f_out_data;
      end
      if (ctrl_write_strobe) begin
         case (ctrl_word_index)
            `CVI_IDX_CTRL: begin
               r_nxt.go = ctrl_write_bus[`CVI_CTRL_GO];
               r_nxt.int_en = ctrl_write_bus[`CVI_CTRL_INTEN];
            end
            `CVI_IDX_STATUS: begin
               if (ctrl_write_bus[`CVI_ST_OVF]) begin
                  r_nxt.ovf = 1'b0;
               end
            end
            `CVI_IDX_INT: begin
               if (ctrl_write_bus[`CVI_INT_UPD]) begin
                  r_nxt.int_flag = smp & (v_lock != r.lock_d);
               end
            end
            `CVI_IDX_SOF_SMP: r_nxt.sof_smp = ctrl_write_bus[`CVI_SMP_W-1:0];
            `CVI_IDX_SOF_LINE: r_nxt.sof_line = ctrl_write_bus[`CVI_LINE_W-1:0];
            default: r_nxt.go = r.go;
         endcase
      end
      // Set after clear: a drop in the clearing cycle still sticks.
      if (r.push_v && !f_in_ready) begin
         r_nxt.ovf = 1'b1;
         r_nxt.int_flag = 1'b1;
      end
      if (ctrl_read_strobe) begin
         case (ctrl_word_index)
            `CVI_IDX_CTRL:     r_nxt.rdata = `CVI_BUS_W'({r.int_en, r.go});
            `CVI_IDX_STATUS:   r_nxt.rdata = `CVI_BUS_W'({v_f, v_lock, r.ovf,
                                                       r.mode == cvi_pkg::CVI_RUN});
            `CVI_IDX_INT:      r_nxt.rdata = `CVI_BUS_W'({r.int_flag, 1'b0});
            `CVI_IDX_STD:      r_nxt.rdata = std_word;
            `CVI_IDX_SOF_SMP:  r_nxt.rdata = `CVI_BUS_W'(r.sof_smp);
            `CVI_IDX_SOF_LINE: r_nxt.rdata = `CVI_BUS_W'(r.sof_line);
            default:           r_nxt.rdata = `CVI_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   cvi_fifo #(.W(FW), .D(DEPTH)) u_fifo (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .in_valid  (r.push_v),
      .in_ready  (f_in_ready),
      .in_data   (r.push_w),
      .out_valid (f_out_valid),
      .out_ready (take),
      .out_data  (f_out_data)
   );

   assign stream_pixel_bus   = r.out_w[DW-1:0];
   assign stream_frame_begin = r.out_w[SOP];
   assign stream_frame_end   = r.out_w[EOP];
   assign stream_beat_valid  = r.out_v;
   assign overflow           = r.ovf;
   assign refclk_div         = r.refclk;
   assign sof                = r.sof;
   assign sof_locked         = r.sof_lock;
   assign ctrl_read_bus      = r.rdata;
   assign status_update_int  = r.int_en & r.int_flag;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_stall;
      stream_beat_valid && !stream_sink_ready;
   endsequence
   sequence s_held;
      stream_beat_valid && $stable(stream_pixel_bus) && $stable(stream_frame_begin)
         && $stable(stream_frame_end);
   endsequence
   sequence s_frame_close;
      vs_rise && r.mode == cvi_pkg::CVI_RUN && r.pend_v;
   endsequence

   a_stall_hold : assert property (s_stall |=> s_held)
      else $error("stream beat changed while stalled");
   a_eop_close : assert property (s_frame_close |=> r.push_v && r.push_w[EOP])
      else $error("frame closed without end flag");
   a_sop_arm : assert property (vs_fall && r.mode == cvi_pkg::CVI_WAIT && r.go && v_lock
                                |=> r.first && r.mode == cvi_pkg::CVI_RUN)
      else $error("frame begin not armed at frame start");
   a_refclk_cause : assert property (hs_rise |=> refclk_div ##1 !refclk_div)
      else $error("reference pulse missing or too long");
   a_sof_pos : assert property ($rose(sof) |-> $past(smp)
                                && $past(r.line_cnt) == $past(r.sof_line)
                                && $past(r.smp_cnt) == $past(r.sof_smp))
      else $error("frame start rose off position");
   a_lock_gate : assert property (sof_locked |-> $past(r.seen_sof) && $past(v_lock))
      else $error("frame lock without a seen frame start");
   a_ovf_sticky : assert property (r.push_v && !f_in_ready |=> overflow)
      else $error("drop did not raise overflow");
   a_irq_after : assert property (smp && v_lock != r.lock_d && r.int_en
                                  && !ctrl_write_strobe |=> status_update_int)
      else $error("interrupt missing after status update");
   a_std_read : assert property (ctrl_read_strobe && ctrl_word_index == `CVI_IDX_STD
                                 |=> ctrl_read_bus == $past(std_word))
      else $error("standard register read wrong");
   a_go_write : assert property (ctrl_write_strobe && ctrl_word_index == `CVI_IDX_CTRL
                                 |=> r.go == $past(ctrl_write_bus[`CVI_CTRL_GO]))
      else $error("control write not stored");
endmodule : cvi_port
`default_nettype wire

// File: rtl/cvi_regs.svh
`ifndef CVI_REGS_SVH
`define CVI_REGS_SVH
`define CVI_IDX_W        3
`define CVI_IDX_CTRL     3'h0
`define CVI_IDX_STATUS   3'h1
`define CVI_IDX_INT      3'h2
`define CVI_IDX_STD      3'h3
`define CVI_IDX_SOF_SMP  3'h4
`define CVI_IDX_SOF_LINE 3'h5
`define CVI_CTRL_GO      0
`define CVI_CTRL_INTEN   1
`define CVI_ST_RUN       0
`define CVI_ST_OVF       1
`define CVI_ST_LOCK      2
`define CVI_ST_FIELD     3
`define CVI_INT_UPD      1
`define CVI_SMP_W        14
`define CVI_LINE_W       13
`define CVI_BUS_W        32
`define CVI_RST_WORD     32'h0000_0000
`endif

// File: tb/clocked_video_input_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cvi_regs.svh"
module clocked_video_input_port_tb_top;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        want_lock = 1'b0;
   logic        want_par = 1'b1;
   logic [1:0]  rdy_mode = 2'h0;
   logic [0:0]  vid_std = 1'b1;
   logic [2:0]  idx = 3'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        vclk, vf, hs, vs, dv, de, pfs, lock, rdy;
   logic [23:0] vdata, pix;
   logic        sop, eop, val, ovf, refd, sof, sofl, irq;
   logic [31:0] rdata;
   logic [25:0] beats[$];
   int          error_cnt = 0;
   int          n_compared = 0;
   int          ref_cnt = 0, ref_wide = 0, sof_cnt = 0;
   logic        refd_q = 1'b0, sof_q = 1'b0;
   always #2.5 core_clk = ~core_clk;
   cvi_port #(.DEPTH(8)) DUT (
      .core_clk(core_clk), .nrst(nrst), .vid_clk(vclk), .vid_data(vdata),
      .vid_datavalid(dv), .vid_f(vf), .vid_h_sync(hs), .vid_v_sync(vs),
      .plane_format_select(pfs), .vid_locked(lock), .active_region_enable(de),
      .vid_std(vid_std), .stream_pixel_bus(pix), .stream_frame_begin(sop),
      .stream_frame_end(eop), .stream_beat_valid(val), .stream_sink_ready(rdy),
      .overflow(ovf), .refclk_div(refd), .sof(sof), .sof_locked(sofl),
      .ctrl_word_index(idx), .ctrl_read_strobe(rd), .ctrl_write_strobe(wr),
      .ctrl_write_bus(wdata), .ctrl_read_bus(rdata), .status_update_int(irq));
   cvi_vid_src src (
      .core_clk(core_clk), .want_lock(want_lock), .want_par(want_par),
      .rdy_mode(rdy_mode), .vid_clk(vclk), .vid_data(vdata), .vid_datavalid(dv),
      .vid_f(vf), .vid_h_sync(hs), .vid_v_sync(vs), .vid_locked(lock),
      .plane_format_select(pfs), .active_region_enable(de), .stream_sink_ready(rdy));
   always @(posedge core_clk) begin
      if (val === 1'b1 && rdy === 1'b1) beats.push_back({sop, eop, pix});
      if (refd === 1'b1 && refd_q === 1'b1) ref_wide++;
      if (refd === 1'b1) ref_cnt++;
      if (sof === 1'b1 && sof_q === 1'b0) sof_cnt++;
      refd_q = refd;
      sof_q = sof;
   end
   task automatic print_verdict;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic timeout(input string what);
      error_cnt++;
      $display("CHECK FAILED at %0t: timeout on %s", $time, what);
      print_verdict();
   endtask : timeout
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic reg_wr(input logic [2:0] i, input logic [31:0] d);
      tick(1);
      idx = i;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [2:0] i, output logic [31:0] d);
      tick(1);
      idx = i;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(1);
      d = rdata;
   endtask : reg_rd
   task automatic t_regs;
      logic [31:0] d;
      reg_wr(`CVI_IDX_SOF_SMP, 32'hFFFF_FFFF);
      reg_wr(`CVI_IDX_SOF_LINE, 32'h1);
      reg_rd(`CVI_IDX_SOF_SMP, d);
      chk(d, 32'h0000_3FFF, "sample field");
      reg_rd(`CVI_IDX_SOF_LINE, d);
      chk(d, 32'h1, "line field");
      reg_wr(`CVI_IDX_SOF_SMP, 32'h0);
      reg_wr(`CVI_IDX_STD, 32'h0);
      reg_rd(`CVI_IDX_STD, d);
      chk(d, 32'h1, "standard bus");
      vid_std = 1'b0;
      tick(2);
      reg_rd(`CVI_IDX_STD, d);
      chk(d, 32'h0, "standard bus low");
      vid_std = 1'b1;
      reg_rd(3'h6, d);
      chk(d, 32'h0, "unmapped index");
      reg_wr(`CVI_IDX_CTRL, 32'h1);
      want_lock = 1'b1;
   endtask : t_regs
   task automatic t_frame(input logic par, input logic [1:0] mode, input logic [7:0] base);
      logic [7:0] c;
      int i;
      tick(1);
      want_par = par;
      rdy_mode = mode;
      beats.delete();
      ref_cnt = 0;
      ref_wide = 0;
      sof_cnt = 0;
      src.send_frame(3, 4, base);
      for (i = 0; i < 2000 && beats.size() < 12; i++) tick(1);
      if (i == 2000) timeout("frame beats");
      tick(8);
      chk(beats.size(), 12, "beat count");
      for (int k = 0; k < 12; k++) begin
         c = base + 8'(3 * k);
         chk(beats[k], {k == 0, k == 11, c + 8'h2, c + 8'h1, c}, "beat");
      end
      chk(ref_cnt, 3, "line pulses");
      chk(ref_wide, 0, "line pulse width");
      chk(sof_cnt, 1, "frame start rises");
      chk(sofl, 1'b1, "frame start lock");
   endtask : t_frame
   task automatic t_irq;
      logic [31:0] d;
      chk(irq, 1'b0, "masked interrupt");
      reg_rd(`CVI_IDX_INT, d);
      chk(d[`CVI_INT_UPD], 1'b1, "update flag");
      reg_wr(`CVI_IDX_CTRL, 32'h3);
      tick(2);
      chk(irq, 1'b1, "enabled interrupt");
      reg_wr(`CVI_IDX_INT, 32'h2);
      tick(2);
      chk(irq, 1'b0, "cleared interrupt");
   endtask : t_irq
   task automatic t_overflow;
      logic [31:0] d;
      int i;
      int quiet;
      tick(1);
      rdy_mode = 2'h2;
      beats.delete();
      src.send_frame(2, 8, 8'h80);
      chk(ovf, 1'b1, "overflow pin");
      reg_rd(`CVI_IDX_STATUS, d);
      chk(d[`CVI_ST_OVF], 1'b1, "overflow status");
      chk(d[`CVI_ST_RUN], 1'b1, "running status");
      chk(irq, 1'b1, "overflow interrupt");
      rdy_mode = 2'h0;
      quiet = 0;
      for (i = 0; i < 300 && quiet < 4; i++) begin
         tick(1);
         quiet = (val === 1'b0) ? quiet + 1 : 0;
      end
      if (i == 300) timeout("drain");
      chk(beats[0][25], 1'b1, "first beat after stall");
      chk(beats.size() < 16, 1'b1, "words dropped when full");
      reg_wr(`CVI_IDX_STATUS, 32'h2);
      reg_wr(`CVI_IDX_INT, 32'h2);
      reg_rd(`CVI_IDX_STATUS, d);
      chk(d[`CVI_ST_OVF], 1'b0, "overflow cleared");
      chk(ovf, 1'b0, "overflow pin cleared");
   endtask : t_overflow
   task automatic t_unlock;
      logic [31:0] d;
      want_lock = 1'b0;
      src.send_frame(1, 2, 8'h00);
      tick(4);
      chk(sofl, 1'b0, "lock lost");
      reg_rd(`CVI_IDX_STATUS, d);
      chk(d[`CVI_ST_LOCK], 1'b0, "lock status");
      chk(d[`CVI_ST_RUN], 1'b0, "stopped status");
      chk(d[`CVI_ST_FIELD], 1'b0, "field status");
   endtask : t_unlock
   task automatic t_async_reset;
      logic [31:0] d;
      reg_rd(`CVI_IDX_STD, d);
      nrst = 1'b0;
      #1;
      chk(rdata, 32'h0, "read bus in reset");
      tick(3);
      nrst = 1'b1;
      reg_rd(`CVI_IDX_CTRL, d);
      chk(d, 32'h0, "control after reset");
   endtask : t_async_reset
   initial begin
      tick(5);
      chk(val, 1'b0, "valid in reset");
      chk(rdata, 32'h0, "read bus in reset");
      tick(1);
      nrst = 1'b1;
      t_regs();
      t_frame(1'b1, 2'h1, 8'h10);
      t_irq();
      t_frame(1'b0, 2'h0, 8'h40);
      t_overflow();
      t_unlock();
      t_async_reset();
      print_verdict();
   end
endmodule : clocked_video_input_port_tb_top
`default_nettype wire

// File: tb/cvi_vid_src.sv
`timescale 1ns/10ps
`default_nettype none
module cvi_vid_src (
   // Stream clock
   input  wire logic       core_clk,
   // Bench requests
   input  wire logic       want_lock,
   input  wire logic       want_par,
   input  wire logic [1:0] rdy_mode,
   // Video source
   output logic            vid_clk,
   output logic [23:0]     vid_data,
   output logic            vid_datavalid,
   output logic            vid_f,
   output logic            vid_h_sync,
   output logic            vid_v_sync,
   output logic            vid_locked,
   output logic            plane_format_select,
   output logic            active_region_enable,
   // Stream sink
   output logic            stream_sink_ready
);
   logic [2:0] cnt_r = 3'h0;
   assign vid_locked           = want_lock;
   assign plane_format_select  = want_par;
   assign active_region_enable = vid_datavalid;
   assign vid_f                = 1'b0;
   initial begin
      vid_clk = 1'b0;
      vid_data = 24'h0;
      vid_datavalid = 1'b0;
      vid_h_sync = 1'b0;
      vid_v_sync = 1'b0;
   end
   // The video clock runs only while a frame is sent; inputs move after its rising edge.
   task automatic step(input logic h, input logic v, input logic dv, input logic [23:0] d);
      vid_clk = 1'b1;
      #1;
      vid_h_sync = h;
      vid_v_sync = v;
      vid_datavalid = dv;
      vid_data = dv ? d : ~vid_data;
      #79;
      vid_clk = 1'b0;
      #80;
   endtask : step
   task automatic send_frame(input int lines, input int pix, input logic [7:0] base);
      logic [7:0] c;
      #2.3;
      step(1'b0, 1'b1, 1'b0, 24'h0);
      step(1'b0, 1'b1, 1'b0, 24'h0);
      step(1'b0, 1'b0, 1'b0, 24'h0);
      for (int l = 0; l < lines; l++) begin
         step(1'b1, 1'b0, 1'b0, 24'h0);
         for (int k = 0; k < pix; k++) begin
            c = base + 8'(3 * (l * pix + k));
            if (want_par) begin
               step(1'b0, 1'b0, 1'b1, {c + 8'h2, c + 8'h1, c});
            end else begin
               for (int p = 0; p < 3; p++) step(1'b0, 1'b0, 1'b1, {16'h0, c + 8'(p)});
            end
         end
      end
      step(1'b0, 1'b1, 1'b0, 24'h0);
      step(1'b0, 1'b1, 1'b0, 24'h0);
   endtask : send_frame
   always @(posedge core_clk) begin
      #1;
      cnt_r <= cnt_r + 3'h1;
      stream_sink_ready <= (rdy_mode == 2'h0) || (rdy_mode == 2'h1 && cnt_r[1]);
   end
endmodule : cvi_vid_src
`default_nettype wire
